// file: hdl/lsag_addr.sv
// address and writeback value calculation, offset range check
// assumes a decoded request held stable by the caller; purely combinational
`timescale 1ns/100ps
module lsag_addr
(
	input  wire lsag_pkg::lsag_req_t req,
	output logic [31:0]              acc_addr,
	output logic [31:0]              wb_addr,
	output logic                     range_bad
);
	logic [31:0] off;
	logic [31:0] eff;

	// offset value: scaled index, immediate, or zero when absent
	always_comb
	begin
		if (req.mode == lsag_pkg::MODE_REGOFF)
			off = req.index_val << req.shift;
		else if (req.off_present)
			off = 32'(req.imm);
		else
			off = 32'h0000_0000;
		if (req.off_add || req.mode == lsag_pkg::MODE_REGOFF)
			eff = req.base_val + off;
		else
			eff = req.base_val - off;
		// post-indexed uses the untouched base for the access
		acc_addr = (req.mode == lsag_pkg::MODE_POST) ? req.base_val : eff;
		wb_addr  = eff;
	end

	// offset range per transfer family
	always_comb
	begin
		range_bad = 1'b0;
		if (req.unpriv)
			range_bad = (req.mode != lsag_pkg::MODE_OFFSET) || (req.off_present
				&& (!req.off_add || req.imm > lsag_pkg::IMM_MAX_IDX));
		else if (req.mode == lsag_pkg::MODE_REGOFF)
			range_bad = 1'b0;
		else if (!req.off_present)
			range_bad = 1'b0;
		else if (req.size == lsag_pkg::SZ_DWORD)
			range_bad = ((req.imm & lsag_pkg::DUAL_ALIGN_MASK) != 12'h000)
				|| (req.imm > lsag_pkg::IMM_MAX_DUAL);
		else if (req.mode == lsag_pkg::MODE_OFFSET && req.off_add)
			range_bad = req.imm > lsag_pkg::IMM_MAX_PLAIN;
		else
			range_bad = req.imm > lsag_pkg::IMM_MAX_IDX;
	end
endmodule

// file: hdl/lsag_ext.sv
// zero or sign extension of loaded bytes and halfwords
// assumes memory returns the addressed data right-aligned in the low bits
`timescale 1ns/100ps
module lsag_ext
(
	input  wire logic [31:0]         rdata,
	input  wire lsag_pkg::lsag_size_t size,
	input  wire logic                sign_ext,
	output logic [31:0]              data
);
	// extend by size; words and double words pass through
	always_comb
	begin
		case (size)
			lsag_pkg::SZ_BYTE:
				data = sign_ext ? {{24{rdata[7]}}, rdata[7:0]}
					: {24'h00_0000, rdata[7:0]};
			lsag_pkg::SZ_HALF:
				data = sign_ext ? {{16{rdata[15]}}, rdata[15:0]}
					: {16'h0000, rdata[15:0]};
			default:
				data = rdata;
		endcase
	end
endmodule

// file: hdl/lsag_pkg.sv
// types and constants of the load/store address generator
// assumes one core clock; all users refer to items as lsag_pkg::name
package lsag_pkg;

	// register numbers with special meaning
	localparam logic [3:0]  REG_SP          = 4'hd;
	localparam logic [3:0]  REG_PC          = 4'hf;

	// offset magnitude limits
	localparam logic [11:0] IMM_MAX_PLAIN   = 12'h0fff;
	localparam logic [11:0] IMM_MAX_IDX     = 12'h00ff;
	localparam logic [11:0] IMM_MAX_DUAL    = 12'h03fc;
	localparam logic [11:0] DUAL_ALIGN_MASK = 12'h0003;

	// address step to the second word, branch target mask
	localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
	localparam logic [31:0] PC_LSB_MASK     = 32'hffff_fffe;

	// transfer sizes
	typedef enum logic [1:0] {
		SZ_BYTE  = 2'b00,
		SZ_HALF  = 2'b01,
		SZ_WORD  = 2'b10,
		SZ_DWORD = 2'b11
	} lsag_size_t;

	// addressing modes
	typedef enum logic [1:0] {
		MODE_OFFSET = 2'b00,
		MODE_PRE    = 2'b01,
		MODE_POST   = 2'b10,
		MODE_REGOFF = 2'b11
	} lsag_mode_t;

	// controller states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACC1 = 2'b01,
		ST_ACC2 = 2'b10
	} lsag_st_t;

	// one decoded transfer from the instruction stream
	typedef struct packed {
		logic        is_load;
		lsag_size_t  size;
		logic        sign_ext;
		lsag_mode_t  mode;
		logic        unpriv;
		logic        off_present;
		logic        off_add;
		logic [11:0] imm;
		logic [1:0]  shift;
		logic [3:0]  transfer_reg;
		logic [3:0]  second_transfer_reg;
		logic [3:0]  base_reg;
		logic [31:0] base_val;
		logic [31:0] index_val;
		logic [31:0] wdata;
		logic [31:0] wdata2;
		logic        privileged;
	} lsag_req_t;

	// complete state of the top module
	typedef struct packed {
		lsag_st_t    st;
		lsag_req_t   req;
		logic        ready;
		logic [31:0] addr2;
		logic [31:0] wb_base;
		logic        mem_req;
		logic [31:0] mem_addr;
		logic        mem_we;
		logic [31:0] mem_wdata;
		lsag_size_t  mem_size;
		logic        mem_user;
		logic        wb_valid;
		logic [3:0]  wb_reg;
		logic [31:0] wb_data;
		logic        wb2_valid;
		logic [3:0]  wb2_reg;
		logic [31:0] wb2_data;
		logic        base_wb_valid;
		logic [3:0]  base_wb_reg;
		logic [31:0] base_wb_data;
		logic        branch_valid;
		logic [31:0] branch_target;
		logic        done;
		logic        range_err;
	} lsag_state_t;

endpackage

// file: hdl/lsag_top.sv
// load/store execution: address generation, memory sequencing, writeback
// assumes a decoded request port from the instruction stream and a memory
// port that answers each held request with a one-cycle mem_ack
//
// What this block does
// - plain offset: base plus/minus offset, no writeback
// - pre-indexed: access at sum, write sum back
// - post-indexed: access at base, write sum back
// - byte/half/word/dword; zero or sign extend loads
// - single immediate offset ranges, plain and indexed
// - dual offsets multiple of four, within 1020
// - missing offset means address is the base
// - loads fill, stores write, one or two registers
// - pc word load branches with bit zero cleared
// - register offset: base plus index shifted 0-3
// - unprivileged offset 0 to 255, absent means base
// - unprivileged transfers always use user permission
// - unprivileged from user equals ordinary transfer
// - condition flags are never modified
`timescale 1ns/100ps
module lsag_top
(
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire logic                 req_valid,
	input  wire lsag_pkg::lsag_req_t  req_in,
	output logic                      req_ready,
	output logic                      mem_req,
	output logic [31:0]               mem_addr,
	output logic                      mem_we,
	output logic [31:0]               mem_wdata,
	output lsag_pkg::lsag_size_t      mem_size,
	output logic                      mem_user,
	input  wire logic                 mem_ack,
	input  wire logic [31:0]          mem_rdata,
	output logic                      wb_valid,
	output logic [3:0]                wb_reg,
	output logic [31:0]               wb_data,
	output logic                      wb2_valid,
	output logic [3:0]                wb2_reg,
	output logic [31:0]               wb2_data,
	output logic                      base_wb_valid,
	output logic [3:0]                base_wb_reg,
	output logic [31:0]               base_wb_data,
	output logic                      branch_valid,
	output logic [31:0]               branch_target,
	output logic                      done,
	output logic                      range_err
);
	lsag_pkg::lsag_state_t s_r;
	lsag_pkg::lsag_state_t s_nxt;
	logic                  accept;
	logic [31:0]           acc_addr;
	logic [31:0]           wb_addr;
	logic                  range_bad;
	logic [31:0]           ext_data;
	logic                  is_dual;
	logic                  pc_word_load;

	// address path works on the incoming request
	lsag_addr u_addr
	(
		.req       (req_in),
		.acc_addr  (acc_addr),
		.wb_addr   (wb_addr),
		.range_bad (range_bad)
	);

	// extension works on the latched request
	lsag_ext u_ext
	(
		.rdata    (mem_rdata),
		.size     (s_r.req.size),
		.sign_ext (s_r.req.sign_ext & s_r.req.is_load),
		.data     (ext_data)
	);

	// handy decodes
	assign accept       = req_valid & s_r.ready;
	assign is_dual      = (s_r.req.size == lsag_pkg::SZ_DWORD);
	assign pc_word_load = s_r.req.is_load && (s_r.req.size == lsag_pkg::SZ_WORD)
		&& (s_r.req.transfer_reg == lsag_pkg::REG_PC);

	// next state; register combinations are trusted, not checked
	always_comb
	begin
		s_nxt               = s_r;
		s_nxt.wb_valid      = 1'b0;
		s_nxt.wb2_valid     = 1'b0;
		s_nxt.base_wb_valid = 1'b0;
		s_nxt.branch_valid  = 1'b0;
		s_nxt.done          = 1'b0;
		s_nxt.range_err     = 1'b0;
		case (s_r.st)
			lsag_pkg::ST_IDLE:
			begin
				if (accept)
				begin
					s_nxt.req = req_in;
					if (range_bad)
					begin
						// out-of-range offset: no access, report at once
						s_nxt.done      = 1'b1;
						s_nxt.range_err = 1'b1;
					end
					else
					begin
						s_nxt.st        = lsag_pkg::ST_ACC1;
						s_nxt.ready     = 1'b0;
						s_nxt.mem_req   = 1'b1;
						s_nxt.mem_addr  = acc_addr;
						s_nxt.addr2     = acc_addr + lsag_pkg::WORD_STEP;
						s_nxt.wb_base   = wb_addr;
						s_nxt.mem_we    = ~req_in.is_load;
						s_nxt.mem_wdata = req_in.wdata;
						s_nxt.mem_size  = (req_in.size == lsag_pkg::SZ_DWORD)
							? lsag_pkg::SZ_WORD : req_in.size;
						// user permission forced for unprivileged forms
						s_nxt.mem_user  = req_in.unpriv | ~req_in.privileged;
					end
				end
			end
			lsag_pkg::ST_ACC1:
			begin
				if (mem_ack)
				begin
					s_nxt.wb_reg  = s_r.req.transfer_reg;
					s_nxt.wb_data = ext_data;
					if (is_dual)
					begin
						// second word four bytes up
						s_nxt.st        = lsag_pkg::ST_ACC2;
						s_nxt.mem_addr  = s_r.addr2;
						s_nxt.mem_wdata = s_r.req.wdata2;
					end
					else
					begin
						s_nxt.st      = lsag_pkg::ST_IDLE;
						s_nxt.ready   = 1'b1;
						s_nxt.mem_req = 1'b0;
						s_nxt.done    = 1'b1;
						if (pc_word_load)
						begin
							s_nxt.branch_valid  = 1'b1;
							s_nxt.branch_target = ext_data & lsag_pkg::PC_LSB_MASK;
						end
						else
							s_nxt.wb_valid = s_r.req.is_load;
					end
				end
			end
			lsag_pkg::ST_ACC2:
			begin
				if (mem_ack)
				begin
					s_nxt.st        = lsag_pkg::ST_IDLE;
					s_nxt.ready     = 1'b1;
					s_nxt.mem_req   = 1'b0;
					s_nxt.done      = 1'b1;
					s_nxt.wb_valid  = s_r.req.is_load;
					s_nxt.wb2_valid = s_r.req.is_load;
					s_nxt.wb2_reg   = s_r.req.second_transfer_reg;
					s_nxt.wb2_data  = ext_data;
				end
			end
			default:
			begin
				s_nxt.st      = lsag_pkg::ST_IDLE;
				s_nxt.ready   = 1'b1;
				s_nxt.mem_req = 1'b0;
			end
		endcase
		// base writeback with the last access; same register as a transfer is trusted away
		if ((s_r.st != lsag_pkg::ST_IDLE) && s_nxt.done
			&& (s_r.req.mode == lsag_pkg::MODE_PRE || s_r.req.mode == lsag_pkg::MODE_POST))
		begin
			s_nxt.base_wb_valid = 1'b1;
			s_nxt.base_wb_reg   = s_r.req.base_reg;
			s_nxt.base_wb_data  = s_r.wb_base;
		end
	end

	// state register
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			s_r       <= '0;
			s_r.st    <= lsag_pkg::ST_IDLE;
			s_r.ready <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// outputs straight from the state register; no flag write path exists
	assign req_ready     = s_r.ready;
	assign mem_req       = s_r.mem_req;
	assign mem_addr      = s_r.mem_addr;
	assign mem_we        = s_r.mem_we;
	assign mem_wdata     = s_r.mem_wdata;
	assign mem_size      = s_r.mem_size;
	assign mem_user      = s_r.mem_user;
	assign wb_valid      = s_r.wb_valid;
	assign wb_reg        = s_r.wb_reg;
	assign wb_data       = s_r.wb_data;
	assign wb2_valid     = s_r.wb2_valid;
	assign wb2_reg       = s_r.wb2_reg;
	assign wb2_data      = s_r.wb2_data;
	assign base_wb_valid = s_r.base_wb_valid;
	assign base_wb_reg   = s_r.base_wb_reg;
	assign base_wb_data  = s_r.base_wb_data;
	assign branch_valid  = s_r.branch_valid;
	assign branch_target = s_r.branch_target;
	assign done          = s_r.done;
	assign range_err     = s_r.range_err;

	// plain offset access address and no base writeback
	a_plain_addr: assert property (@(posedge clk_sys) disable iff (srst)
		accept && !range_bad && !req_in.unpriv && req_in.mode == lsag_pkg::MODE_OFFSET
		&& req_in.off_present && req_in.off_add
		|=> mem_addr == $past(req_in.base_val) + 32'($past(req_in.imm)))
		else $error("plain offset address wrong");

	a_plain_no_wb: assert property (@(posedge clk_sys) disable iff (srst)
		done && s_r.req.mode == lsag_pkg::MODE_OFFSET |-> !base_wb_valid)
		else $error("plain offset wrote the base");

	a_pre_index: assert property (@(posedge clk_sys) disable iff (srst)
		base_wb_valid && s_r.req.mode == lsag_pkg::MODE_PRE && !is_dual
		|-> base_wb_data == $past(mem_addr))
		else $error("pre-index writeback differs from access address");

	a_post_index: assert property (@(posedge clk_sys) disable iff (srst)
		accept && !range_bad && req_in.mode == lsag_pkg::MODE_POST
		|=> mem_addr == $past(req_in.base_val))
		else $error("post-index access not at base");

	a_sign_byte: assert property (@(posedge clk_sys) disable iff (srst)
		wb_valid && s_r.req.size == lsag_pkg::SZ_BYTE
		|-> wb_data[31:8] == (s_r.req.sign_ext ? {24{wb_data[7]}} : 24'h00_0000))
		else $error("byte load extension wrong");

	a_dual_range: assert property (@(posedge clk_sys) disable iff (srst)
		accept && !req_in.unpriv && req_in.size == lsag_pkg::SZ_DWORD
		&& req_in.mode != lsag_pkg::MODE_REGOFF && req_in.off_present
		&& (req_in.imm & lsag_pkg::DUAL_ALIGN_MASK) != 12'h000
		|=> range_err && done && !mem_req)
		else $error("misaligned dual offset accepted");

	a_index_range: assert property (@(posedge clk_sys) disable iff (srst)
		accept && req_in.size != lsag_pkg::SZ_DWORD && req_in.mode == lsag_pkg::MODE_PRE
		&& req_in.off_present && req_in.imm > lsag_pkg::IMM_MAX_IDX
		|=> range_err)
		else $error("pre-index offset above limit accepted");

	a_no_offset: assert property (@(posedge clk_sys) disable iff (srst)
		accept && !range_bad && !req_in.off_present && req_in.mode != lsag_pkg::MODE_REGOFF
		|=> mem_addr == $past(req_in.base_val))
		else $error("absent offset not at base");

	a_second_word: assert property (@(posedge clk_sys) disable iff (srst)
		s_r.st == lsag_pkg::ST_ACC1 && mem_ack && is_dual
		|=> mem_req && mem_addr == $past(mem_addr) + lsag_pkg::WORD_STEP)
		else $error("second word address wrong");

	a_branch_lsb: assert property (@(posedge clk_sys) disable iff (srst)
		s_r.st == lsag_pkg::ST_ACC1 && mem_ack && pc_word_load
		|=> branch_valid && !wb_valid && branch_target == ($past(mem_rdata) & lsag_pkg::PC_LSB_MASK))
		else $error("pc load branch target wrong");

	a_reg_offset: assert property (@(posedge clk_sys) disable iff (srst)
		accept && !range_bad && req_in.mode == lsag_pkg::MODE_REGOFF
		|=> mem_addr == $past(req_in.base_val) + ($past(req_in.index_val) << $past(req_in.shift)))
		else $error("register offset address wrong");

	a_user_perm: assert property (@(posedge clk_sys) disable iff (srst)
		mem_req && s_r.req.unpriv |-> mem_user)
		else $error("unprivileged access without user permission");

	a_load_fill: assert property (@(posedge clk_sys) disable iff (srst)
		done && !range_err && s_r.req.is_load && is_dual |-> wb_valid && wb2_valid)
		else $error("dual load did not fill both registers");

	a_sign_half: assert property (@(posedge clk_sys) disable iff (srst)
		wb_valid && s_r.req.size == lsag_pkg::SZ_HALF
		|-> wb_data[31:16] == (s_r.req.sign_ext ? {16{wb_data[15]}} : 16'h0000))
		else $error("halfword load extension wrong");

	a_user_equal: assert property (@(posedge clk_sys) disable iff (srst)
		mem_req && !s_r.req.privileged |-> mem_user)
		else $error("user caller access without user permission");

	a_range_no_acc: assert property (@(posedge clk_sys) disable iff (srst)
		done && range_err |-> !mem_req && req_ready)
		else $error("rejected offset still started an access");
endmodule

// file: test/lsag_mem_model.sv
// memory partner for lsag_top: stores words, answers after a set wait
// assumes registered, held requests; addresses fold into a 1 KiB window
`timescale 1ns/100ps
module lsag_mem_model
(
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire logic [3:0]           lat,
	input  wire logic                 mem_req,
	input  wire logic [31:0]          mem_addr,
	input  wire logic                 mem_we,
	input  wire logic [31:0]          mem_wdata,
	input  wire lsag_pkg::lsag_size_t mem_size,
	output logic                      mem_ack,
	output logic [31:0]               mem_rdata
);
	logic [31:0] mem_r [256];
	logic [31:0] last_r;
	logic [3:0]  wait_r;
	logic [31:0] mask;

	// ack after lat waiting cycles of a held request, never outside one
	assign mem_ack = mem_req && (wait_r == lat);
	// released data lines show the inverse of the last word, not a stale copy
	assign mem_rdata = mem_ack ? mem_r[mem_addr[9:2]] : ~last_r;
	// stores keep only the lanes of their size
	assign mask = (mem_size == lsag_pkg::SZ_BYTE) ? 32'h0000_00ff :
		(mem_size == lsag_pkg::SZ_HALF) ? 32'h0000_ffff : 32'hffff_ffff;

	// wait counter and storage; unwritten words read as the inverted address
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wait_r <= 4'h0;
			last_r <= 32'h0000_0000;
			for (int i = 0; i < 256; i++)
				mem_r[i] <= ~{22'h0, i[7:0], 2'h0};
		end
		else
		begin
			wait_r <= (!mem_req || mem_ack) ? 4'h0 : wait_r + 4'h1;
			if (mem_ack)
				last_r <= mem_rdata;
			if (mem_ack && mem_we)
				mem_r[mem_addr[9:2]] <= mem_wdata & mask;
		end
	end
endmodule

// file: test/lsag_top_tb.sv
// self-checking bench for lsag_top, one task per scenario
// assumes lsag_mem_model as the memory side; one clock, synchronous reset
`timescale 1ns/100ps
module lsag_top_tb;
	logic                 clk_sys, srst, req_valid, req_ready, mem_req, mem_we, mem_user;
	logic                 mem_ack, wb_valid, wb2_valid, base_wb_valid, branch_valid, done;
	logic                 range_err;
	logic [3:0]           wb_reg, wb2_reg, base_wb_reg, lat;
	logic [31:0]          mem_addr, mem_wdata, mem_rdata, wb_data, wb2_data, base_wb_data;
	logic [31:0]          branch_target;
	lsag_pkg::lsag_size_t mem_size;
	lsag_pkg::lsag_req_t  req_in, r;
	logic [31:0]          acc_a[$], acc_d[$];
	logic                 acc_w[$], acc_u[$];
	int                   n_errors, check_count;

	// device and memory partner
	lsag_top u_lsag_top
	(
		.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req_in(req_in),
		.req_ready(req_ready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .mem_size(mem_size), .mem_user(mem_user), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .wb_valid(wb_valid), .wb_reg(wb_reg), .wb_data(wb_data),
		.wb2_valid(wb2_valid), .wb2_reg(wb2_reg), .wb2_data(wb2_data),
		.base_wb_valid(base_wb_valid), .base_wb_reg(base_wb_reg),
		.base_wb_data(base_wb_data), .branch_valid(branch_valid),
		.branch_target(branch_target), .done(done), .range_err(range_err)
	);
	lsag_mem_model u_lsag_mem_model
	(
		.clk_sys(clk_sys), .srst(srst), .lat(lat), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_we(mem_we), .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);

	// 10 MHz core clock
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// log every access the partner accepts
	always @(posedge clk_sys)
		if (mem_req === 1'b1 && mem_ack === 1'b1)
		begin
			acc_a.push_back(mem_addr);
			acc_d.push_back(mem_wdata);
			acc_w.push_back(mem_we);
			acc_u.push_back(mem_user);
		end

	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk32(nm, {31'h0, e}, {31'h0, g});
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// word load, legal registers only: distinct, base and index never pc
	task automatic base_req(input logic [31:0] b);
		r = '0;
		r.is_load = 1'b1;
		r.size = lsag_pkg::SZ_WORD;
		r.off_present = 1'b1;
		r.off_add = 1'b1;
		r.transfer_reg = 4'h1;
		r.second_transfer_reg = 4'h2;
		r.base_reg = 4'h3;
		r.base_val = b;
		r.privileged = 1'b1;
	endtask

	// present r, then wait a bounded time for done
	task automatic xfer(input logic [3:0] l);
		int n;
		n = 0;
		// let an edge pass so req_valid never drops and rises in one step
		@(posedge clk_sys);
		#10 lat = l;
		acc_a.delete();
		acc_d.delete();
		acc_w.delete();
		acc_u.delete();
		req_in = r;
		req_valid = 1'b1;
		@(posedge clk_sys);
		#10 req_valid = 1'b0;
		while (done !== 1'b1 && n < 40)
		begin
			@(posedge clk_sys);
			#10 n++;
		end
		chk1("done", 1'b1, done);
	endtask

	task automatic s_modes;
		logic [31:0] a;
		for (int m = 0; m < 3; m++)
		begin
			base_req(32'h0000_0200);
			r.mode = lsag_pkg::lsag_mode_t'(m);
			r.off_add = 1'b0;
			r.imm = 12'h010;
			xfer(m[3:0]);
			a = (m == 2) ? 32'h0000_0200 : 32'h0000_01f0;
			chk32("addr", a, acc_a[0]);
			chk32("load", ~a, wb_data);
			chk1("user", 1'b0, acc_u[0]);
			chk1("base wb", m != 0, base_wb_valid);
			chk32("dest reg", 32'h0000_0001, {28'h0, wb_reg});
			if (m != 0)
			begin
				chk32("base val", 32'h0000_01f0, base_wb_data);
				chk32("base reg", 32'h0000_0003, {28'h0, base_wb_reg});
			end
		end
	endtask

	task automatic s_ext;
		logic [31:0] xv [5] = '{32'h0000_00f0, 32'hffff_fff0, 32'h0000_80f0,
			32'hffff_80f0, 32'h8765_80f0};
		base_req(32'h0000_0100);
		r.is_load = 1'b0;
		r.wdata = 32'h8765_80f0;
		xfer(4'h1);
		chk1("store we", 1'b1, acc_w[0]);
		chk32("store data", 32'h8765_80f0, acc_d[0]);
		chk1("store no wb", 1'b0, wb_valid);
		// byte store keeps only its lane, so a word load sees the low byte
		base_req(32'h0000_0104);
		r.is_load = 1'b0;
		r.size = lsag_pkg::SZ_BYTE;
		r.wdata = 32'h1234_56a5;
		xfer(4'h0);
		base_req(32'h0000_0104);
		xfer(4'h0);
		chk32("byte lane", 32'h0000_00a5, wb_data);
		for (int k = 0; k < 5; k++)
		begin
			base_req(32'h0000_0100);
			r.size = lsag_pkg::lsag_size_t'(k / 2);
			r.sign_ext = k[0];
			xfer(4'h0);
			chk32("extend", xv[k], wb_data);
		end
	endtask

	task automatic rng(input logic dw, input logic [1:0] md, input logic ad, input logic up,
		input logic [11:0] im, input logic er);
		base_req(32'h0000_0200);
		r.size = dw ? lsag_pkg::SZ_DWORD : lsag_pkg::SZ_WORD;
		r.mode = lsag_pkg::lsag_mode_t'(md);
		r.off_add = ad;
		r.unpriv = up;
		r.imm = im;
		xfer(4'h0);
		chk1("range err", er, range_err);
		chk32("accesses", er ? 32'h0 : (dw ? 32'h2 : 32'h1), 32'(acc_a.size()));
	endtask

	task automatic s_ranges;
		rng(1'b0, 2'h0, 1'b1, 1'b0, 12'hfff, 1'b0);
		rng(1'b0, 2'h0, 1'b0, 1'b0, 12'h0ff, 1'b0);
		rng(1'b0, 2'h0, 1'b0, 1'b0, 12'h100, 1'b1);
		rng(1'b0, 2'h1, 1'b1, 1'b0, 12'h0ff, 1'b0);
		rng(1'b0, 2'h1, 1'b1, 1'b0, 12'h100, 1'b1);
		rng(1'b0, 2'h2, 1'b0, 1'b0, 12'h100, 1'b1);
		rng(1'b1, 2'h0, 1'b1, 1'b0, 12'h3fc, 1'b0);
		rng(1'b1, 2'h2, 1'b0, 1'b0, 12'h400, 1'b1);
		rng(1'b1, 2'h1, 1'b1, 1'b0, 12'h3fe, 1'b1);
		rng(1'b0, 2'h0, 1'b1, 1'b1, 12'h0ff, 1'b0);
		rng(1'b0, 2'h0, 1'b1, 1'b1, 12'h100, 1'b1);
	endtask

	task automatic s_dword;
		base_req(32'h0000_0300);
		r.size = lsag_pkg::SZ_DWORD;
		r.mode = lsag_pkg::MODE_PRE;
		r.imm = 12'h008;
		xfer(4'h2);
		chk32("first addr", 32'h0000_0308, acc_a[0]);
		chk32("first data", 32'hffff_fcf7, wb_data);
		chk32("second addr", 32'h0000_030c, acc_a[1]);
		chk32("second data", 32'hffff_fcf3, wb2_data);
		chk32("second reg", 32'h0000_0002, {28'h0, wb2_reg});
		chk32("dw base", 32'h0000_0308, base_wb_data);
		base_req(32'h0000_0320);
		r.is_load = 1'b0;
		r.size = lsag_pkg::SZ_DWORD;
		r.mode = lsag_pkg::MODE_POST;
		r.off_add = 1'b0;
		r.imm = 12'h010;
		r.wdata2 = 32'h3333_4444;
		xfer(4'h0);
		chk32("st addr", 32'h0000_0324, acc_a[1]);
		chk32("st data", 32'h3333_4444, acc_d[1]);
		chk32("st base", 32'h0000_0310, base_wb_data);
	endtask

	task automatic s_regoff;
		for (int s = 0; s < 4; s++)
		begin
			base_req(32'h0000_0100);
			r.mode = lsag_pkg::MODE_REGOFF;
			r.shift = s[1:0];
			r.index_val = 32'h0000_0014;
			r.imm = 12'hfff;
			xfer(4'h0);
			chk32("reg addr", 32'h0000_0100 + (32'h0000_0014 << s), acc_a[0]);
			chk1("reg no base wb", 1'b0, base_wb_valid);
		end
	endtask

	task automatic s_branch;
		base_req(32'h0000_0080);
		r.is_load = 1'b0;
		r.wdata = 32'h0000_0245;
		xfer(4'h0);
		base_req(32'h0000_0080);
		r.transfer_reg = lsag_pkg::REG_PC;
		xfer(4'h3);
		chk1("branch", 1'b1, branch_valid);
		chk32("target", 32'h0000_0244, branch_target);
		chk1("branch no wb", 1'b0, wb_valid);
	endtask

	// privileged and user callers, offset present and absent
	task automatic s_unpriv;
		logic [31:0] a;
		for (int k = 0; k < 3; k++)
		begin
			base_req(32'h0000_0040);
			r.unpriv = (k < 2);
			r.privileged = (k == 0);
			r.off_present = (k != 1);
			r.imm = (k == 1) ? 12'hfff : 12'h020;
			xfer(4'h1);
			a = (k == 1) ? 32'h0000_0040 : 32'h0000_0060;
			chk32("unpriv addr", a, acc_a[0]);
			chk32("unpriv data", ~a, wb_data);
			chk1("user", 1'b1, acc_u[0]);
		end
	endtask

	// main sequence after 8 cycles of reset
	initial
	begin
		srst = 1'b1;
		req_valid = 1'b0;
		req_in = '0;
		lat = 4'h0;
		n_errors = 0;
		check_count = 0;
		repeat (8) @(posedge clk_sys);
		#10 srst = 1'b0;
		chk1("ready", 1'b1, req_ready);
		chk1("idle mem", 1'b0, mem_req);
		s_modes();
		s_ext();
		s_ranges();
		s_dword();
		s_regoff();
		s_branch();
		s_unpriv();
		final_report();
	end

	// the run needs about 120 cycles; cut it off well beyond
	initial
	begin
		#500_000;
		n_errors++;
		final_report();
	end
endmodule
